/* File: hdl/sysint_pkg.sv */
// constants, types and bus carriers for the reset source and break status block
// assumes sys_clk_i is the crystal clock and the cpu bus is synchronous to it
//
// Function
// - a flag records that a break interrupt ended wait mode.
// - the break status flag only works while in emulation mode.
// - break wait-exit flag reads 1 after break exit, else 0.
// - a cpu read of the reset cause register clears all its flags, except in break with clearing disabled.
// - power-on reset leaves only the power-on flag set.
// - flags accumulate until software clears them by reading.
// - the reset pin is driven low during power-on or internal reset.
// - pin sampled 32 clocks after release; low sets the external-pin flag.
// - external-pin flag marks a pin reset; cleared by power-on or read.
// - watchdog flag marks a watchdog reset; cleared by power-on or read.
// - bad opcode flag marks an undefined opcode reset; cleared likewise.
// - bad fetch flag set only by opcode fetches from unimplemented addresses.
// - monitor entry flag marks a reset caused by monitor mode entry.
// - low voltage flag marks a low-voltage inhibit reset; cleared likewise.
// - break clear enable bit is read/write and gates clearing during break.
// - a break interrupt while in wait mode sets the wait-exit flag.
// - two-step clears stay protected during break while clearing is disabled.
// - a flag cleared in break with clearing enabled stays cleared.
package sysint_pkg;

	// ==================================================================
	// register map
	localparam logic [15:0] BREAK_STATUS_ADDR = 16'hfe00;
	localparam logic [15:0] RESET_CAUSE_ADDR = 16'hfe01;
	localparam logic [15:0] BREAK_CTRL_ADDR = 16'hfe03;

	// ==================================================================
	// field positions
	localparam int unsigned WAIT_EXIT_BIT = 1;
	localparam int unsigned POR_BIT = 7;
	localparam int unsigned PIN_BIT = 6;
	localparam int unsigned WDOG_BIT = 5;
	localparam int unsigned OPCODE_BIT = 4;
	localparam int unsigned FETCH_BIT = 3;
	localparam int unsigned MONITOR_BIT = 2;
	localparam int unsigned LOW_VOLT_BIT = 1;
	localparam int unsigned CLEAR_EN_BIT = 7;

	// ==================================================================
	// reset values
	localparam logic [7:0] RESET_CAUSE_RESET = 8'h80;
	localparam logic BREAK_FLAG_RESET = 1'b0;
	localparam logic CLEAR_EN_RESET = 1'b0;

	// ==================================================================
	// timing counts, in crystal clock cycles
	localparam int unsigned CNT_W = 6;
	localparam logic [CNT_W-1:0] DRIVE_CYCLES = 6'h30;
	localparam logic [CNT_W-1:0] PIN_SAMPLE_CYCLES = 6'h20;

	// ==================================================================
	// types
	typedef enum logic [2:0] {
		ST_DRIVE = 3'b001,
		ST_RELEASE = 3'b010,
		ST_IDLE = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic watchdog;
		logic bad_opcode;
		logic bad_address;
		logic opcode_fetch;
		logic monitor_entry;
		logic low_voltage;
	} reset_cause_t;

	typedef struct packed {
		logic emulation;
		logic break_irq;
		logic wait_mode;
		logic break_state;
	} break_ctx_t;

endpackage

/* File: hdl/reset_source_and_break_status.sv */
// reset source flags, reset pin sequencing and break status registers
// assumes all inputs except the asynchronous reset_n_i are synchronous to sys_clk_i and reset causes are pulses
`timescale 1ns/10ps

module reset_source_and_break_status (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire sysint_pkg::bus_req_t bus_i,
	output logic [7:0] rdata_o,
	input wire sysint_pkg::reset_cause_t cause_i,
	input wire sysint_pkg::break_ctx_t brk_i,
	input wire logic reset_pin_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_o,
	output logic system_reset_o,
	output logic break_clear_enable_o,
	output logic status_clear_permit_o
);

	// ==================================================================
	// address decode
	function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
		hit = (addr == reg_addr);
	endfunction

	sysint_pkg::seq_state_t state;
	sysint_pkg::seq_state_t next_state;
	logic [sysint_pkg::CNT_W-1:0] count;
	logic [sysint_pkg::CNT_W-1:0] next_count;
	logic [7:0] reset_cause;
	logic [7:0] cause_set;
	logic [5:0] cause_vec;
	logic break_flag;
	logic clear_en;
	logic clear_permit;
	logic internal_req;
	logic pin_low_seen;
	logic read_clear;
	logic status_clear;

	// clearing is protected while in break unless the enable bit is set
	assign clear_permit = !brk_i.break_state || clear_en;
	assign read_clear = bus_i.rd && hit(bus_i.addr, sysint_pkg::RESET_CAUSE_ADDR)
		&& clear_permit;
	assign status_clear = bus_i.wr && hit(bus_i.addr, sysint_pkg::BREAK_STATUS_ADDR)
		&& !bus_i.wdata[sysint_pkg::WAIT_EXIT_BIT] && clear_permit;

	// data accesses to unimplemented space carry no opcode_fetch and so set nothing
	// a pin pulled low from outside while idle is an external reset too
	assign cause_vec[0] = pin_low_seen
		|| (state == sysint_pkg::ST_IDLE && !reset_pin_i);
	assign cause_vec[1] = cause_i.watchdog;
	assign cause_vec[2] = cause_i.bad_opcode;
	assign cause_vec[3] = cause_i.bad_address && cause_i.opcode_fetch;
	assign cause_vec[4] = cause_i.monitor_entry;
	assign cause_vec[5] = cause_i.low_voltage;
	assign internal_req = |cause_vec[5:1];

	// ==================================================================
	// map each cause onto its flag position
	localparam int unsigned CAUSE_POS [6] = '{
		sysint_pkg::PIN_BIT, sysint_pkg::WDOG_BIT, sysint_pkg::OPCODE_BIT,
		sysint_pkg::FETCH_BIT, sysint_pkg::MONITOR_BIT, sysint_pkg::LOW_VOLT_BIT
	};
	generate
		for (genvar i = 0; i < 6; i++) begin : g_cause
			assign cause_set[CAUSE_POS[i]] = cause_vec[i];
		end
	endgenerate
	// power-on is only ever set by the asynchronous reset; bit 0 is unused
	assign cause_set[sysint_pkg::POR_BIT] = 1'b0;
	assign cause_set[0] = 1'b0;

	// ==================================================================
	// reset pin sequencer: drive low, release, then sample after the delay
	always_comb begin
		next_state = state;
		next_count = count;
		unique case (state)
			sysint_pkg::ST_DRIVE: begin
				if (count == '0) begin
					next_state = sysint_pkg::ST_RELEASE;
					next_count = sysint_pkg::PIN_SAMPLE_CYCLES - 1'b1;
				end else begin
					next_count = count - 1'b1;
				end
			end
			sysint_pkg::ST_RELEASE: begin
				if (count == '0) begin
					next_state = sysint_pkg::ST_IDLE;
				end else begin
					next_count = count - 1'b1;
				end
			end
			sysint_pkg::ST_IDLE: begin
				// a low pin while not driving it is an external reset
				if (!reset_pin_i) begin
					next_state = sysint_pkg::ST_DRIVE;
					next_count = sysint_pkg::DRIVE_CYCLES - 1'b1;
				end
			end
		endcase
		// a new internal cause restarts the sequence from any state
		if (internal_req) begin
			next_state = sysint_pkg::ST_DRIVE;
			next_count = sysint_pkg::DRIVE_CYCLES - 1'b1;
		end
	end

	// sample point: last cycle of the release window
	assign pin_low_seen = (state == sysint_pkg::ST_RELEASE) && (count == '0)
		&& !reset_pin_i;

	// power-on starts in the drive phase so the pin is pulled low at once
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= sysint_pkg::ST_DRIVE;
			count <= sysint_pkg::DRIVE_CYCLES - 1'b1;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// pin outputs track the next state so they switch with the state itself
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_pin_o <= 1'b0;
			reset_pin_oe_o <= 1'b1;
			system_reset_o <= 1'b1;
		end else begin
			reset_pin_o <= 1'b0;
			reset_pin_oe_o <= (next_state == sysint_pkg::ST_DRIVE);
			system_reset_o <= (next_state != sysint_pkg::ST_IDLE);
		end
	end

	// ==================================================================
	// reset cause flags: sets win over a read clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_cause <= sysint_pkg::RESET_CAUSE_RESET;
		end else begin
			// flags only accumulate until software reads them
			reset_cause <= (reset_cause & ~{8{read_clear}}) | cause_set;
		end
	end

	// break wait-exit flag is only set while emulation is active
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			break_flag <= sysint_pkg::BREAK_FLAG_RESET;
		end else begin
			break_flag <= (break_flag && !status_clear)
				|| (brk_i.emulation && brk_i.break_irq && brk_i.wait_mode);
		end
	end

	// break clear enable, read/write
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clear_en <= sysint_pkg::CLEAR_EN_RESET;
		end else if (bus_i.wr && hit(bus_i.addr, sysint_pkg::BREAK_CTRL_ADDR)) begin
			clear_en <= bus_i.wdata[sysint_pkg::CLEAR_EN_BIT];
		end
	end

	// other modules gate both steps of their clears on this permit, so a first
	// step done before break cannot finish the clear inside protected break
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			break_clear_enable_o <= sysint_pkg::CLEAR_EN_RESET;
			status_clear_permit_o <= 1'b1;
		end else begin
			break_clear_enable_o <= next_clear_en();
			status_clear_permit_o <= !brk_i.break_state || next_clear_en();
		end
	end

	function automatic logic next_clear_en();
		if (bus_i.wr && hit(bus_i.addr, sysint_pkg::BREAK_CTRL_ADDR)) begin
			next_clear_en = bus_i.wdata[sysint_pkg::CLEAR_EN_BIT];
		end else begin
			next_clear_en = clear_en;
		end
	endfunction

	// ==================================================================
	// read data captured from pre-clear values; zero when idle or unmapped
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 8'h00;
		end else if (bus_i.rd) begin
			rdata_o <= 8'h00;
			if (hit(bus_i.addr, sysint_pkg::BREAK_STATUS_ADDR)) begin
				// outside emulation the flag means nothing, so it reads as zero
				rdata_o[sysint_pkg::WAIT_EXIT_BIT] <= break_flag && brk_i.emulation;
			end else if (hit(bus_i.addr, sysint_pkg::RESET_CAUSE_ADDR)) begin
				rdata_o <= reset_cause;
			end else if (hit(bus_i.addr, sysint_pkg::BREAK_CTRL_ADDR)) begin
				rdata_o[sysint_pkg::CLEAR_EN_BIT] <= clear_en;
			end
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ==================================================================
	// checks
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	break_flag_set_a:
	assert property (brk_i.emulation && brk_i.break_irq && brk_i.wait_mode |=> break_flag)
		else $error("break in wait did not set the wait-exit flag");

	break_flag_cause_a:
	assert property ($rose(break_flag)
		|-> $past(brk_i.emulation && brk_i.break_irq && brk_i.wait_mode))
		else $error("wait-exit flag rose without a break in wait");

	break_flag_read_a:
	assert property (bus_i.rd && hit(bus_i.addr, sysint_pkg::BREAK_STATUS_ADDR)
		&& brk_i.emulation |=> rdata_o[sysint_pkg::WAIT_EXIT_BIT] == $past(break_flag))
		else $error("wait-exit flag read back wrong");

	break_emul_read_a:
	assert property (bus_i.rd && !brk_i.emulation |=> rdata_o[sysint_pkg::WAIT_EXIT_BIT] == 1'b0
		|| $past(!hit(bus_i.addr, sysint_pkg::BREAK_STATUS_ADDR)))
		else $error("break status visible outside emulation");

	cause_read_clear_a:
	assert property (read_clear && cause_set == 8'h00 |=> reset_cause == 8'h00)
		else $error("reset cause read did not clear the flags");

	cause_read_data_a:
	assert property (bus_i.rd && hit(bus_i.addr, sysint_pkg::RESET_CAUSE_ADDR)
		|=> rdata_o == $past(reset_cause))
		else $error("reset cause read returned cleared data");

	cause_accumulate_a:
	assert property (!read_clear |=> (reset_cause & $past(reset_cause)) == $past(reset_cause))
		else $error("a reset cause flag dropped without a read");

	por_only_reset_a:
	assert property (!$rose(reset_cause[sysint_pkg::POR_BIT]))
		else $error("power-on flag set outside power-on reset");

	pin_drive_a:
	assert property (internal_req |=> reset_pin_oe_o && !reset_pin_o && system_reset_o)
		else $error("internal reset did not pull the pin low");

	pin_sample_a:
	assert property ($fell(reset_pin_oe_o) ##31 (!reset_pin_i && !internal_req)
		|=> reset_cause[sysint_pkg::PIN_BIT])
		else $error("pin low at sample point did not set the pin flag");

	watchdog_flag_a:
	assert property (cause_i.watchdog |=> reset_cause[sysint_pkg::WDOG_BIT])
		else $error("watchdog reset not flagged");

	opcode_flag_a:
	assert property (cause_i.bad_opcode |=> reset_cause[sysint_pkg::OPCODE_BIT])
		else $error("bad opcode reset not flagged");

	fetch_flag_a:
	assert property ($rose(reset_cause[sysint_pkg::FETCH_BIT])
		|-> $past(cause_i.bad_address && cause_i.opcode_fetch))
		else $error("bad fetch flag set by a data access");

	monitor_flag_a:
	assert property (cause_i.monitor_entry |=> reset_cause[sysint_pkg::MONITOR_BIT])
		else $error("monitor entry reset not flagged");

	low_volt_flag_a:
	assert property (cause_i.low_voltage |=> reset_cause[sysint_pkg::LOW_VOLT_BIT])
		else $error("low voltage reset not flagged");

	pin_flag_a:
	assert property ($rose(reset_cause[sysint_pkg::PIN_BIT])
		|-> $past((state == sysint_pkg::ST_RELEASE || state == sysint_pkg::ST_IDLE)
		&& !reset_pin_i))
		else $error("pin flag set without a low sample");

	pin_ext_flag_a:
	assert property (state == sysint_pkg::ST_IDLE && !reset_pin_i
		|=> reset_cause[sysint_pkg::PIN_BIT] && reset_pin_oe_o)
		else $error("external pin reset not flagged");

	break_protect_a:
	assert property (brk_i.break_state && !clear_en ##1 brk_i.break_state
		|-> !status_clear_permit_o && $stable(clear_en) || $past(bus_i.wr))
		else $error("clear permitted during protected break");

	cause_protect_a:
	assert property (bus_i.rd && hit(bus_i.addr, sysint_pkg::RESET_CAUSE_ADDR)
		&& brk_i.break_state && !clear_en
		|=> (reset_cause & $past(reset_cause)) == $past(reset_cause))
		else $error("reset cause cleared during protected break");

	break_cleared_stays_a:
	assert property (status_clear && !brk_i.break_irq |=> !break_flag)
		else $error("flag cleared in break did not stay cleared");

	wait_flag_quiet_a:
	assert property (!break_flag && !(brk_i.emulation && brk_i.break_irq && brk_i.wait_mode)
		|=> !break_flag)
		else $error("wait-exit flag set again without a break in wait");

endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the reset source and break status block
// assumes the reset pin is open-drain with a pull-up and only the block or the bench pulls it
`timescale 1ns/10ps

module tb_top;
	// ==================================================================
	// signals
	logic sys_clk_i;
	logic reset_n_i;
	sysint_pkg::bus_req_t bus;
	sysint_pkg::reset_cause_t cause;
	sysint_pkg::break_ctx_t brk;
	logic ext_low;
	logic reset_pin;
	logic [7:0] rdata;
	logic pin_out;
	logic pin_oe;
	logic sys_rst;
	logic clear_en;
	logic permit;
	int errors;
	int n_checks;
	sysint_pkg::reset_cause_t row_cause [6];
	logic [7:0] row_exp [6];

	// pull-up wins unless somebody pulls low
	assign reset_pin = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;

	reset_source_and_break_status i_dut (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.bus_i(bus),
		.rdata_o(rdata),
		.cause_i(cause),
		.brk_i(brk),
		.reset_pin_i(reset_pin),
		.reset_pin_o(pin_out),
		.reset_pin_oe_o(pin_oe),
		.system_reset_o(sys_rst),
		.break_clear_enable_o(clear_en),
		.status_clear_permit_o(permit)
	);

	// ==================================================================
	// clock and watchdog
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	// about 1200 cycles are expected, so 5000 leaves ample margin
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		errors++;
		$display("BAD watchdog expected finish seen hang");
		end_of_test();
	end

	// ==================================================================
	// tasks, entered and left at a falling edge, except end_of_test when the watchdog calls it at a rising edge
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		n_checks++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, seen);
			errors++;
		end
	endtask

	// strobe for one cycle, then a quiet cycle so back-to-back calls never glitch rd
	task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp, input string what);
		bus.addr = addr;
		bus.rd = 1'b1;
		@(negedge sys_clk_i);
		check(what, exp, rdata);
		bus.rd = 1'b0;
		@(negedge sys_clk_i);
	endtask

	task automatic bus_wr(input logic [15:0] addr, input logic [7:0] data);
		bus.addr = addr;
		bus.wdata = data;
		bus.wr = 1'b1;
		@(negedge sys_clk_i);
		bus.wr = 1'b0;
		@(negedge sys_clk_i);
	endtask

	task automatic pulse_cause(input sysint_pkg::reset_cause_t c);
		cause = c;
		@(negedge sys_clk_i);
		cause = '0;
	endtask

	// bounded wait for the sequencer to go idle
	task automatic wait_idle();
		for (int n = 0; n < 300 && sys_rst !== 1'b0; n++) @(negedge sys_clk_i);
		check("sequencer idle", 8'h00, {7'h00, sys_rst});
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==================================================================
	// main sequence
	initial begin
		reset_n_i = 1'b0;
		bus = '0;
		cause = '0;
		brk = '0;
		ext_low = 1'b0;
		errors = 0;
		n_checks = 0;
		row_cause = '{6'h20, 6'h10, 6'h0c, 6'h08, 6'h02, 6'h01};
		row_exp = '{8'h20, 8'h10, 8'h08, 8'h00, 8'h04, 8'h02};
		repeat (2) @(negedge sys_clk_i);
		check("pin drive in reset", 8'h01, {7'h00, pin_oe});
		reset_n_i = 1'b1;
		wait_idle();
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h80, "power-on flags");
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h00, "flags after read");
		rd_chk(sysint_pkg::BREAK_CTRL_ADDR, 8'h00, "enable at reset");
		rd_chk(sysint_pkg::BREAK_STATUS_ADDR, 8'h00, "wait flag at reset");
		$display("test reset done");

		// one row per internal reset cause; a plain data access to a hole gives no flag
		for (int i = 0; i < 6; i++) begin
			pulse_cause(row_cause[i]);
			if (row_exp[i] !== 8'h00) begin
				check("pin drive", 8'h01, {7'h00, pin_oe & ~pin_out});
			end
			wait_idle();
			check("pin release", 8'h00, {7'h00, pin_oe});
			rd_chk(sysint_pkg::RESET_CAUSE_ADDR, row_exp[i], "cause flag");
		end
		$display("test cause table done");

		// flags pile up until read
		pulse_cause(6'h20);
		wait_idle();
		pulse_cause(6'h01);
		wait_idle();
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h22, "accumulated flags");
		$display("test accumulate done");

		// short external pull while idle
		ext_low = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		ext_low = 1'b0;
		wait_idle();
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h40, "pin flag");
		// pin still held low when sampled after an internal reset
		pulse_cause(6'h20);
		for (int n = 0; n < 100 && pin_oe !== 1'b0; n++) @(negedge sys_clk_i);
		ext_low = 1'b1;
		repeat (40) @(negedge sys_clk_i);
		ext_low = 1'b0;
		wait_idle();
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h60, "late pin sample");
		$display("test pin done");

		// break while waiting in emulation
		brk.emulation = 1'b1;
		brk.wait_mode = 1'b1;
		brk.break_irq = 1'b1;
		@(negedge sys_clk_i);
		brk.break_irq = 1'b0;
		brk.wait_mode = 1'b0;
		rd_chk(sysint_pkg::BREAK_STATUS_ADDR, 8'h02, "wait exit flag");
		brk.emulation = 1'b0;
		rd_chk(sysint_pkg::BREAK_STATUS_ADDR, 8'h00, "flag outside emulation");
		brk.emulation = 1'b1;
		bus_wr(sysint_pkg::BREAK_STATUS_ADDR, 8'h00);
		rd_chk(sysint_pkg::BREAK_STATUS_ADDR, 8'h00, "flag cleared");
		$display("test break flag done");

		// protection in break, then enabled clearing that sticks after break
		pulse_cause(6'h20);
		wait_idle();
		brk.break_state = 1'b1;
		@(negedge sys_clk_i);
		check("permit protected", 8'h00, {7'h00, permit});
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h20, "protected read");
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h20, "still protected");
		bus_wr(sysint_pkg::BREAK_CTRL_ADDR, 8'h80);
		check("enable out", 8'h01, {7'h00, clear_en});
		check("permit enabled", 8'h01, {7'h00, permit});
		rd_chk(sysint_pkg::BREAK_CTRL_ADDR, 8'h80, "enable readback");
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h20, "read in break");
		brk.break_state = 1'b0;
		@(negedge sys_clk_i);
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h00, "stays cleared");
		bus_wr(sysint_pkg::BREAK_CTRL_ADDR, 8'h00);
		rd_chk(sysint_pkg::BREAK_CTRL_ADDR, 8'h00, "enable cleared");
		$display("test protection done");

		// unmapped read and a write to the read-only cause register
		rd_chk(16'hfe02, 8'h00, "unmapped read");
		bus_wr(sysint_pkg::RESET_CAUSE_ADDR, 8'hff);
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h00, "write ignored");
		$display("test refusals done");

		// second power-on in mid-run wipes the other flags
		pulse_cause(6'h01);
		wait_idle();
		reset_n_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		@(negedge sys_clk_i);
		check("pin drive after reset", 8'h01, {7'h00, pin_oe});
		wait_idle();
		rd_chk(sysint_pkg::RESET_CAUSE_ADDR, 8'h80, "power-on again");
		$display("test second reset done");
		end_of_test();
	end
endmodule
